// >>> common/dual_port_pkg.sv
// Shared types and constants for the dual-port arbiter and configuration block
package dual_port_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } i2c_in_t;
    typedef struct packed {
        logic scl;
        logic scl_oe;
        logic sda;
        logic sda_oe;
    } i2c_out_t;
    typedef enum logic [1:0] {OWN_NONE = 2'b00, OWN_DDC = 2'b01, OWN_CTL = 2'b10} owner_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RX = 3'b001,
        S_RACK = 3'b010,
        S_TX = 3'b011,
        S_TACK = 3'b100,
        S_WAIT = 3'b101
    } eng_t;
    typedef enum logic [1:0] {T_MEM = 2'b00, T_SEG = 2'b01, T_CFG = 2'b10, T_NONE = 2'b11} target_t;
    localparam int PORT_DDC = 0;
    localparam int PORT_CTL = 1;
    localparam logic [7:0] ADDR_MEM_WR = 8'ha0;
    localparam logic [7:0] ADDR_MEM_RD = 8'ha1;
    localparam logic [7:0] ADDR_SEG_WR = 8'h60;
    localparam logic [7:0] ADDR_SEG_RD = 8'h61;
    localparam logic [7:0] ADDR_CFG_WR = 8'h62;
    localparam logic [7:0] ADDR_CFG_RD = 8'h63;
    localparam int CFG_SINGLE = 0;
    localparam int CFG_AB0 = 1;
    localparam int CFG_AB1 = 2;
    localparam int CFG_WE = 3;
    localparam logic [7:0] CFG_ERASED = 8'hff;
    localparam logic [7:0] UNDEF_READ = 8'hff;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_SECOND = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam int MEM_DEPTH = 1024;
    localparam int MEM_AW = 10;
    localparam int REF_CLK_HZ = 25000000;
    localparam int RELEASE_TIME_S = 1;
    localparam int RELEASE_CYCLES_DEF = RELEASE_TIME_S * REF_CLK_HZ;
    localparam int IDLE_W = 25;
endpackage : dual_port_pkg

// >>> dv/i2c_master_model.sv
// Behavioural two-wire bus master for one port of the two-port memory
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_low,
    output logic o_sda_low
);
    localparam int HALF_NS = 160;
    localparam int WAIT_LIMIT = 4000;
    logic timed_out;
    initial
    begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
        timed_out = 1'b0;
    end
    task automatic raise_scl();
        int n;
        n = 0;
        o_scl_low = 1'b0;
        while (i_scl !== 1'b1 && n < WAIT_LIMIT)
        begin
            #40;
            n++;
        end
        if (n >= WAIT_LIMIT)
            timed_out = 1'b1;
    endtask : raise_scl
    task automatic bit_xfer(input logic v, output logic seen);
        o_sda_low = ~v;
        #HALF_NS;
        raise_scl();
        #(HALF_NS / 2);
        seen = i_sda;
        #(HALF_NS / 2);
        o_scl_low = 1'b1;
        #40;
    endtask : bit_xfer
    // Kinds: 0 start, 1 stop, 2 write, 3 read with ack, 4 read last, 5 clock pulse
    task automatic do_op(input int k, input logic [7:0] wd, output logic [7:0] rd);
        logic s;
        rd = 8'h00;
        if (k == 0)
        begin
            o_sda_low = 1'b0;
            #HALF_NS;
            raise_scl();
            #HALF_NS;
            o_sda_low = 1'b1;
            #HALF_NS;
            o_scl_low = 1'b1;
            #40;
        end
        else if (k == 1)
        begin
            o_sda_low = 1'b1;
            #HALF_NS;
            raise_scl();
            #HALF_NS;
            o_sda_low = 1'b0;
            #HALF_NS;
        end
        else if (k == 2)
        begin
            for (int i = 7; i >= 0; i--)
                bit_xfer(wd[i], s);
            bit_xfer(1'b1, s);
            rd = {7'h00, ~s};
        end
        else if (k == 3 || k == 4)
        begin
            for (int i = 7; i >= 0; i--)
                bit_xfer(1'b1, rd[i]);
            bit_xfer(k == 4, s);
        end
        else
        begin
            o_scl_low = 1'b1;
            #HALF_NS;
            o_scl_low = 1'b0;
            #40;
        end
    endtask : do_op
endmodule : i2c_master_model

// >>> dv/testbench.sv
// Self-checking bench for the two-port arbiter and bank configuration block
`timescale 1ns/1ps
module testbench;
    localparam int REL = 200;
    typedef struct {int p; logic [7:0] cfg; logic pin; logic up;} row_t;
    row_t rows [8] = '{'{1, 8'h00, 1'b0, 1'b0}, '{0, 8'h00, 1'b1, 1'b1}, '{1, 8'h02, 1'b0, 1'b0},
        '{0, 8'h02, 1'b1, 1'b1}, '{1, 8'h04, 1'b1, 1'b0}, '{0, 8'h06, 1'b0, 1'b1},
        '{1, 8'h0f, 1'b1, 1'b0}, '{0, 8'h01, 1'b1, 1'b0}};
    logic i_ref_clk, i_reset, pin, upper, dm_scl_low, dm_sda_low, cm_scl_low, cm_sda_low;
    dual_port_pkg::i2c_in_t ddc_in, ctl_in;
    dual_port_pkg::i2c_out_t ddc_out, ctl_out;
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] w[$];
    logic [7:0] d[$];
    int err_count, compares, n;
    assign ddc_in = '{scl: ~(dm_scl_low | (ddc_out.scl_oe === 1'b1)), sda: ~(dm_sda_low | (ddc_out.sda_oe === 1'b1))};
    assign ctl_in = '{scl: ~(cm_scl_low | (ctl_out.scl_oe === 1'b1)), sda: ~(cm_sda_low | (ctl_out.sda_oe === 1'b1))};
    dual_port_arbiter_bank_config #(.RELEASE_CYCLES(REL)) dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_ddc(ddc_in), .i_ctl(ctl_in), .i_bank_select_pin(pin), .o_ddc(ddc_out), .o_ctl(ctl_out),
        .o_upper_bank(upper));
    i2c_master_model ddc_m (.i_scl(ddc_in.scl), .i_sda(ddc_in.sda), .o_scl_low(dm_scl_low), .o_sda_low(dm_sda_low));
    i2c_master_model ctl_m (.i_scl(ctl_in.scl), .i_sda(ctl_in.sda), .o_scl_low(cm_scl_low), .o_sda_low(cm_sda_low));
    initial
    begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    task automatic end_of_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask : cyc
    task automatic op(input int p, input int k, input logic [7:0] wd, output logic [7:0] rd);
        if (p == 0)
            ddc_m.do_op(k, wd, rd);
        else
            ctl_m.do_op(k, wd, rd);
        if (ddc_m.timed_out || ctl_m.timed_out)
        begin
            err_count++;
            $display("[FAIL] t=%0t clock hold wait ran out seen=%h exp=%h", $time, 1'b1, 1'b0);
            end_of_test();
        end
    endtask : op
    // Start, the bytes, optional stop; returns the count of acknowledged bytes
    task automatic send(input int p, input logic [7:0] q[$], input logic stop_it, output logic [7:0] acks);
        logic [7:0] x;
        acks = 8'h00;
        op(p, 0, 8'h00, x);
        foreach (q[i])
        begin
            op(p, 2, q[i], x);
            acks = acks + x;
        end
        if (stop_it)
            op(p, 1, 8'h00, x);
    endtask : send
    task automatic fetch(input int p, input logic [7:0] adr, input int k, output logic [7:0] q[$]);
        logic [7:0] x;
        q = {};
        op(p, 0, 8'h00, x);
        op(p, 2, adr, x);
        for (int i = 0; i < k; i++)
        begin
            op(p, (i == k - 1) ? 4 : 3, 8'h00, x);
            q.push_back(x);
        end
        op(p, 1, 8'h00, x);
    endtask : fetch
    task automatic seg_read(input int p, input logic [7:0] seg, input logic [7:0] off, input int k);
        send(p, '{dual_port_pkg::ADDR_SEG_WR, seg}, 1'b0, a);
        send(p, '{dual_port_pkg::ADDR_MEM_WR, off}, 1'b0, a);
        fetch(p, dual_port_pkg::ADDR_MEM_RD, k, d);
    endtask : seg_read
    initial
    begin
        i_reset = 1'b1;
        pin = 1'b0;
        err_count = 0;
        compares = 0;
        cyc(12);
        i_reset = 1'b0;
        cyc(4);
        check({4'h0, ddc_out.scl_oe, ddc_out.sda_oe, ctl_out.scl_oe, ctl_out.sda_oe}, 8'h00);
        check({7'h00, upper}, 8'h00);
        fetch(1, dual_port_pkg::ADDR_CFG_RD, 1, d);
        check(d[0], dual_port_pkg::CFG_ERASED);
        $display("reset test done");
        foreach (rows[i])
        begin
            pin = rows[i].pin;
            send(rows[i].p, '{dual_port_pkg::ADDR_CFG_WR, 8'h00, rows[i].cfg}, 1'b1, a);
            check(a, 8'h03);
            cyc(8);
            check({7'h00, upper}, {7'h00, rows[i].up});
            fetch(1 - rows[i].p, dual_port_pkg::ADDR_CFG_RD, 1, d);
            check({4'h0, d[0][3:0]}, {4'h0, rows[i].cfg[3:0]});
        end
        $display("bank table test done");
        send(1, '{dual_port_pkg::ADDR_CFG_WR, 8'h00, 8'h06}, 1'b0, a);
        cyc(8);
        check({7'h00, upper}, 8'h00);
        op(1, 1, 8'h00, r);
        cyc(8);
        check({7'h00, upper}, 8'h01);
        $display("config timing test done");
        send(1, '{dual_port_pkg::ADDR_SEG_WR, 8'h00}, 1'b0, a);
        send(1, '{dual_port_pkg::ADDR_MEM_WR, 8'h00, 8'hc5}, 1'b1, a);
        send(1, '{dual_port_pkg::ADDR_SEG_WR, 8'h03}, 1'b0, a);
        check(a, 8'h02);
        w = '{dual_port_pkg::ADDR_MEM_WR, 8'hf8};
        for (int i = 0; i < 16; i++)
            w.push_back(8'h30 + 8'(i));
        send(1, w, 1'b1, a);
        check(a, 8'h12);
        seg_read(1, 8'h03, 8'hf8, 16);
        foreach (d[i])
            check(d[i], 8'h30 + 8'(i));
        seg_read(1, 8'h00, 8'h00, 1);
        check(d[0], 8'hc5);
        $display("controller memory test done");
        send(0, '{dual_port_pkg::ADDR_CFG_WR, 8'h00, 8'h0e}, 1'b1, a);
        send(0, '{dual_port_pkg::ADDR_SEG_WR, 8'h00}, 1'b0, a);
        send(0, '{dual_port_pkg::ADDR_MEM_WR, 8'h10, 8'h5a}, 1'b1, a);
        check(a, 8'h03);
        send(0, '{dual_port_pkg::ADDR_CFG_WR, 8'h00, 8'h06}, 1'b1, a);
        send(0, '{dual_port_pkg::ADDR_SEG_WR, 8'h00}, 1'b0, a);
        send(0, '{dual_port_pkg::ADDR_MEM_WR, 8'h10, 8'ha5}, 1'b1, a);
        check(a, 8'h02);
        seg_read(0, 8'h00, 8'h10, 1);
        check(d[0], 8'h5a);
        send(0, '{8'h50}, 1'b1, a);
        check(a, 8'h00);
        fetch(0, dual_port_pkg::ADDR_SEG_RD, 1, d);
        check(d[0], dual_port_pkg::UNDEF_READ);
        $display("write gating test done");
        cyc(REL + 40);
        check({6'h00, ddc_out.scl_oe, ctl_out.scl_oe}, 8'h00);
        op(0, 0, 8'h00, r);
        check({6'h00, ddc_out.scl_oe, ctl_out.scl_oe}, 8'h01);
        op(0, 1, 8'h00, r);
        cyc(REL - 40);
        check({7'h00, ctl_out.scl_oe}, 8'h01);
        op(0, 5, 8'h00, r);
        n = 0;
        while (ctl_out.scl_oe === 1'b1 && n < 1000)
        begin
            cyc(1);
            n++;
        end
        check({7'h00, 1'(n >= REL - 4 && n <= REL + 8)}, 8'h01);
        check({7'h00, ctl_out.scl_oe}, 8'h00);
        $display("arbitration test done");
        end_of_test();
    end
endmodule : testbench

// >>> hdl/dual_port_arbiter_bank_config.sv
// Two-port serial memory: clock-hold arbitration, bank configuration, segment pointer
// How it works
// - Both clocks idle: hold neither line
// - START on a port while no port owns holds other clock low; DDC wins same-cycle STARTs
// - Owner clock high one second: release other
// - Single-bank bit picks one or two banks
// - DDC memory writes need write-enable bit set
// - Controller port writes always allowed
// - Bank from pin or low select bit
// - Single-bank mode forces the lower bank
// - Config byte answers at 62h and 63h
// - Config read: address, data, no-ack, stop
// - Config write: address, dummy, data, stop
// - Segment pointer write precedes repeated START access
// - Page write takes any number of bytes
// - Segment pointer write-only at 60h; 61h undefined
// - Controller port reaches four 256-byte segments
// - Word offset steps and wraps in segment
`timescale 1ns/1ps
module dual_port_arbiter_bank_config #(
    parameter int unsigned RELEASE_CYCLES = dual_port_pkg::RELEASE_CYCLES_DEF
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire dual_port_pkg::i2c_in_t i_ddc,
    input wire dual_port_pkg::i2c_in_t i_ctl,
    input wire logic i_bank_select_pin,
    output dual_port_pkg::i2c_out_t o_ddc,
    output dual_port_pkg::i2c_out_t o_ctl,
    output logic o_upper_bank
);
    localparam int IW = dual_port_pkg::IDLE_W;
    localparam logic [IW-1:0] REL_LAST = IW'(RELEASE_CYCLES - 1);

    typedef struct packed {
        logic [1:0] scl_m;
        logic [1:0] sda_m;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] scl_p;
        logic [1:0] sda_p;
        logic [1:0] pin_sync;
        dual_port_pkg::owner_t owner;
        logic [IW-1:0] idle_cnt;
        dual_port_pkg::eng_t eng;
        dual_port_pkg::target_t tgt;
        logic rnw;
        logic [1:0] phase;
        logic [3:0] bits;
        logic [7:0] shift;
        logic [7:0] offset;
        logic [1:0] seg;
        logic [7:0] cfg;
        logic [7:0] cfg_new;
        logic cfg_pend;
        logic sda_oe;
    } st_t;

    st_t q;
    st_t d;
    logic [7:0] mem [0:dual_port_pkg::MEM_DEPTH-1];
    logic [1:0] start_det;
    logic own_idx;
    logic scl_now;
    logic sda_now;
    logic rise;
    logic fall;
    logic stop_det;
    logic bank;
    logic [dual_port_pkg::MEM_AW-1:0] mem_addr;
    logic [7:0] rd_byte;
    logic mem_we;

    // Per-port START: data falls while clock stays high
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            assign start_det[p] = q.scl_s[p] & q.scl_p[p] & q.sda_p[p] & ~q.sda_s[p];
        end
    endgenerate

    // engine listens only to owner port
    assign own_idx = (q.owner == dual_port_pkg::OWN_CTL);
    assign scl_now = q.scl_s[own_idx];
    assign sda_now = q.sda_s[own_idx];
    assign rise = scl_now & ~q.scl_p[own_idx];
    assign fall = ~scl_now & q.scl_p[own_idx];
    assign stop_det = scl_now & q.scl_p[own_idx] & ~q.sda_p[own_idx] & sda_now;

    // single bank collapses the DDC map
    // pin or low select bit picks bank
    assign bank = q.cfg[dual_port_pkg::CFG_SINGLE] ? 1'b0 :
                  (q.cfg[dual_port_pkg::CFG_AB1] ? q.cfg[dual_port_pkg::CFG_AB0] : q.pin_sync[1]);
    // controller port uses both segment bits
    assign mem_addr = (q.owner == dual_port_pkg::OWN_CTL) ? {q.seg, q.offset} : {bank, q.seg[0], q.offset};

    always_comb
    begin
        case (q.tgt)
            dual_port_pkg::T_MEM: rd_byte = mem[mem_addr];
            dual_port_pkg::T_CFG: rd_byte = q.cfg;
            default: rd_byte = dual_port_pkg::UNDEF_READ;
        endcase
    end

    always_comb
    begin
        logic ack;
        logic claim;
        ack = 1'b0;
        claim = 1'b0;
        d = q;
        mem_we = 1'b0;
        d.scl_m = {i_ctl.scl, i_ddc.scl};
        d.sda_m = {i_ctl.sda, i_ddc.sda};
        d.scl_s = q.scl_m;
        d.sda_s = q.sda_m;
        d.scl_p = q.scl_s;
        d.sda_p = q.sda_s;
        d.pin_sync = {q.pin_sync[0], i_bank_select_pin};
        // inactive until a START is seen
        if (q.owner == dual_port_pkg::OWN_NONE)
        begin
            if (start_det[dual_port_pkg::PORT_DDC])
            begin
                d.owner = dual_port_pkg::OWN_DDC;
                claim = 1'b1;
            end
            else if (start_det[dual_port_pkg::PORT_CTL])
            begin
                d.owner = dual_port_pkg::OWN_CTL;
                claim = 1'b1;
            end
            d.idle_cnt = '0;
        end
        else
        begin
            claim = start_det[own_idx];
            if (!scl_now)
                d.idle_cnt = '0;
            else if (q.idle_cnt == REL_LAST)
            begin
                d.owner = dual_port_pkg::OWN_NONE;
                d.idle_cnt = '0;
            end
            else
                d.idle_cnt = q.idle_cnt + 1'b1;
        end
        if (claim)
        begin
            d.eng = dual_port_pkg::S_RX;
            d.bits = '0;
            d.phase = dual_port_pkg::PH_ADDR;
            d.sda_oe = 1'b0;
        end
        else if (stop_det && q.owner != dual_port_pkg::OWN_NONE)
        begin
            d.eng = dual_port_pkg::S_IDLE;
            d.sda_oe = 1'b0;
            if (q.cfg_pend)
                d.cfg = q.cfg_new;
            d.cfg_pend = 1'b0;
        end
        else
        begin
            case (q.eng)
                dual_port_pkg::S_RX:
                begin
                    if (rise)
                    begin
                        d.shift = {q.shift[6:0], sda_now};
                        d.bits = q.bits + 4'h1;
                    end
                    else if (fall && q.bits == dual_port_pkg::BITS_BYTE)
                    begin
                        if (q.phase == dual_port_pkg::PH_ADDR)
                        begin
                            case (q.shift)
                                dual_port_pkg::ADDR_MEM_WR, dual_port_pkg::ADDR_MEM_RD: d.tgt = dual_port_pkg::T_MEM;
                                dual_port_pkg::ADDR_SEG_WR, dual_port_pkg::ADDR_SEG_RD: d.tgt = dual_port_pkg::T_SEG;
                                dual_port_pkg::ADDR_CFG_WR, dual_port_pkg::ADDR_CFG_RD: d.tgt = dual_port_pkg::T_CFG;
                                default: d.tgt = dual_port_pkg::T_NONE;
                            endcase
                            ack = (d.tgt != dual_port_pkg::T_NONE);
                            d.rnw = q.shift[0];
                        end
                        else if (q.phase == dual_port_pkg::PH_SECOND)
                        begin
                            if (q.tgt == dual_port_pkg::T_MEM)
                                d.offset = q.shift;
                            else if (q.tgt == dual_port_pkg::T_SEG)
                                d.seg = q.shift[1:0];
                            ack = 1'b1;
                        end
                        else
                        begin
                            ack = 1'b1;
                            if (q.tgt == dual_port_pkg::T_MEM)
                            begin
                                if (q.owner == dual_port_pkg::OWN_DDC && !q.cfg[dual_port_pkg::CFG_WE])
                                    ack = 1'b0;
                                else
                                begin
                                    // each page byte stored, offset steps
                                    mem_we = 1'b1;
                                    d.offset = q.offset + 8'h01;
                                end
                            end
                            else if (q.tgt == dual_port_pkg::T_CFG)
                            begin
                                d.cfg_new = q.shift;
                                d.cfg_pend = 1'b1;
                            end
                        end
                        if (q.phase != dual_port_pkg::PH_DATA)
                            d.phase = q.phase + 2'h1;
                        d.sda_oe = ack;
                        d.eng = ack ? dual_port_pkg::S_RACK : dual_port_pkg::S_WAIT;
                    end
                end
                dual_port_pkg::S_RACK:
                begin
                    if (fall)
                    begin
                        d.bits = '0;
                        if (q.rnw)
                        begin
                            d.shift = rd_byte;
                            d.sda_oe = ~rd_byte[7];
                            d.eng = dual_port_pkg::S_TX;
                        end
                        else
                        begin
                            d.sda_oe = 1'b0;
                            d.eng = dual_port_pkg::S_RX;
                        end
                    end
                end
                dual_port_pkg::S_TX:
                begin
                    if (rise)
                        d.bits = q.bits + 4'h1;
                    else if (fall)
                    begin
                        if (q.bits == dual_port_pkg::BITS_BYTE)
                        begin
                            d.sda_oe = 1'b0;
                            d.eng = dual_port_pkg::S_TACK;
                        end
                        else
                        begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sda_oe = ~q.shift[6];
                        end
                    end
                end
                dual_port_pkg::S_TACK:
                begin
                    if (rise)
                    begin
                        if (sda_now)
                            d.eng = dual_port_pkg::S_WAIT;
                        else
                        begin
                            if (q.tgt == dual_port_pkg::T_MEM)
                                d.offset = q.offset + 8'h01;
                            d.eng = dual_port_pkg::S_RACK;
                        end
                    end
                end
                dual_port_pkg::S_IDLE, dual_port_pkg::S_WAIT:
                    d.sda_oe = 1'b0;
                default:
                    d.eng = dual_port_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            q <= '0;
            q.scl_m <= '1;
            q.sda_m <= '1;
            q.scl_s <= '1;
            q.sda_s <= '1;
            q.scl_p <= '1;
            q.sda_p <= '1;
            q.owner <= dual_port_pkg::OWN_NONE;
            q.eng <= dual_port_pkg::S_IDLE;
            q.tgt <= dual_port_pkg::T_NONE;
            q.cfg <= dual_port_pkg::CFG_ERASED;
        end
        else
            q <= d;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (mem_we)
            mem[mem_addr] <= q.shift;
    end

    assign o_ddc.scl = 1'b0;
    assign o_ddc.scl_oe = (q.owner == dual_port_pkg::OWN_CTL);
    assign o_ddc.sda = 1'b0;
    assign o_ddc.sda_oe = q.sda_oe & (q.owner == dual_port_pkg::OWN_DDC);
    assign o_ctl.scl = 1'b0;
    assign o_ctl.scl_oe = (q.owner == dual_port_pkg::OWN_DDC);
    assign o_ctl.sda = 1'b0;
    assign o_ctl.sda_oe = q.sda_oe & (q.owner == dual_port_pkg::OWN_CTL);
    assign o_upper_bank = bank;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_ddc_claims_idle;
        q.owner == dual_port_pkg::OWN_NONE && start_det[dual_port_pkg::PORT_DDC];
    endsequence
    sequence s_owner_hold_ends;
        q.owner != dual_port_pkg::OWN_NONE && scl_now && q.idle_cnt == REL_LAST;
    endsequence
    sequence s_cfg_addr_byte;
        q.eng == dual_port_pkg::S_RX && fall && q.bits == dual_port_pkg::BITS_BYTE
            && q.phase == dual_port_pkg::PH_ADDR && q.shift == dual_port_pkg::ADDR_CFG_WR;
    endsequence

    a_idle_no_hold: assert property (q.owner == dual_port_pkg::OWN_NONE |-> !o_ddc.scl_oe && !o_ctl.scl_oe)
        else $error("Clock held while arbitration idle");
    a_start_holds_ctl: assert property (s_ddc_claims_idle |=> o_ctl.scl_oe && !o_ddc.scl_oe)
        else $error("Controller clock not held after DDC start");
    a_release_after_hold: assert property (s_owner_hold_ends |=> !o_ddc.scl_oe && !o_ctl.scl_oe)
        else $error("Held clock not released after idle interval");
    a_count_restart: assert property (q.owner != dual_port_pkg::OWN_NONE && !scl_now |=> q.idle_cnt == '0)
        else $error("Release count not restarted on low clock");
    a_single_bank: assert property (q.cfg[dual_port_pkg::CFG_SINGLE] |-> !o_upper_bank)
        else $error("Upper bank used in single-bank mode");
    a_pin_selects: assert property (!q.cfg[dual_port_pkg::CFG_SINGLE] && !q.cfg[dual_port_pkg::CFG_AB1]
        |-> o_upper_bank == $past(i_bank_select_pin, 2))
        else $error("Bank does not follow select pin");
    a_ddc_write_gate: assert property (mem_we && q.owner == dual_port_pkg::OWN_DDC |-> q.cfg[dual_port_pkg::CFG_WE])
        else $error("DDC write with write enable clear");
    a_cfg_holds: assert property (!(stop_det && q.owner != dual_port_pkg::OWN_NONE) |=> $stable(q.cfg))
        else $error("Config changed without STOP");
    a_ctl_segment: assert property (mem_we && q.owner == dual_port_pkg::OWN_CTL |-> mem_addr[9:8] == q.seg)
        else $error("Controller write outside segment");
    a_offset_step: assert property (q.eng == dual_port_pkg::S_TACK && rise && !sda_now
        && q.tgt == dual_port_pkg::T_MEM && !claim_now() |=> q.offset == $past(q.offset) + 8'h01)
        else $error("Read offset did not advance by one");
    a_cfg_addr_ack: assert property (s_cfg_addr_byte ##1 !stop_det[*2] |-> o_ddc.sda_oe || o_ctl.sda_oe)
        else $error("Config write address not acknowledged");

    function automatic logic claim_now();
        claim_now = start_det[own_idx] || stop_det;
    endfunction : claim_now
endmodule : dual_port_arbiter_bank_config
